//--- io_mux_pkg.sv
/*
 * constants, register map and carriers for the camera pin mux
 * assumes a 10 MHz mclk and a 32-bit AXI4-Lite register bus
 */
`default_nettype none
package io_mux_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS    = 100;
    localparam int PULSE_NS  = 2000;               // marker pulse length
    localparam int PULSE_CYC = PULSE_NS / CLK_NS;  // rounds down
    localparam int US_NS     = 1000;
    localparam int US_CYC    = US_NS / CLK_NS;     // cycles per microsecond
    localparam int DELAY_W   = 24;                 // 0 .. 16777215 us

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_IN_MAP  = 8'h00;
    localparam logic [7:0] OFF_OUT_MAP = 8'h04;
    localparam logic [7:0] OFF_CTRL    = 8'h08;
    localparam logic [7:0] OFF_DELAY   = 8'h0C;
    localparam logic [7:0] OFF_EXPTIME = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h14;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int N_IN      = 4;   // cc1, cc2, general a, general b
    localparam int N_OUT     = 3;   // general a, general b, spare link
    localparam int IN_FLD_W  = 4;   // per input nibble
    localparam int OUT_FLD_W = 8;   // per output byte
    localparam int CTRL_EXT_EXP = 0;
    localparam int CTRL_TSRC_LO = 1;

    // input functions
    localparam logic [2:0] IF_NONE  = 3'h0;
    localparam logic [2:0] IF_COMP  = 3'h1;
    localparam logic [2:0] IF_EXT   = 3'h2;
    localparam logic [2:0] IF_EXPO  = 3'h3;
    localparam logic [2:0] IF_LSYNC = 3'h4;
    localparam logic [2:0] IF_FSYNC = 3'h5;

    // output sources, 0 is none
    localparam int N_SRC = 13;
    localparam logic [3:0] OS_STROBE1 = 4'hC;

    // trigger source select
    localparam logic [1:0] TS_EXT  = 2'h0;
    localparam logic [1:0] TS_COMP = 2'h1;
    localparam logic [1:0] TS_PGEN = 2'h2;

    // boot mapping
    localparam logic [31:0] IN_MAP_RST  = 32'h0000_0201;
    localparam logic [31:0] OUT_MAP_RST = 32'h0000_000C;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       active_low;
        logic [2:0] func;
    } in_cfg_s;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       active_low;
        logic [3:0] src;
    } out_cfg_s;

endpackage : io_mux_pkg
`default_nettype wire

//--- camera_io_signal_mux.sv
/*
 * camera pin mux: maps four control inputs onto internal functions
 * and picks one of thirteen internal signals for each of three outputs
 * assumes pins are asynchronous to mclk, core signals are on mclk,
 * and the bus master holds its payload
 */
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module camera_io_signal_mux (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // physical inputs
    input  wire logic        cc1,
    input  wire logic        cc2,
    input  wire logic        general_input_a,
    input  wire logic        general_input_b,
    // physical outputs
    output logic             general_output_a,
    output logic             general_output_b,
    output logic             spare_link_output,
    // core status
    input  wire logic        trigger_mode,
    input  wire logic        exposure_active,
    input  wire logic        line_tick,
    input  wire logic        frame_tick,
    input  wire logic        camera_ready,
    input  wire logic        pulse_gen,
    input  wire logic        strobe_one,
    input  wire logic        strobe_two,
    // functions fed to the core
    output logic             computer_trigger,
    output logic             external_trigger,
    output logic             ext_exposure,
    output logic             line_align,
    output logic             frame_align,
    output logic             exposure_delay_done
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] in_map_q, out_map_q, ctrl_q;
    logic [io_mux_pkg::DELAY_W-1:0] delay_q, exptime_q;
    logic [31:0] status;

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic wr_go, rd_go;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = rd_go;

    // byte lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // register writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_map_q  <= io_mux_pkg::IN_MAP_RST;
            out_map_q <= io_mux_pkg::OUT_MAP_RST;
            ctrl_q    <= io_mux_pkg::CTRL_RST;
            delay_q   <= '0;
            exptime_q <= '0;
        end else if (wr_go) begin
            unique case (s_axi_awaddr)
                io_mux_pkg::OFF_IN_MAP:  in_map_q  <= merge(in_map_q, s_axi_wdata, s_axi_wstrb);
                io_mux_pkg::OFF_OUT_MAP: out_map_q <= merge(out_map_q, s_axi_wdata, s_axi_wstrb);
                io_mux_pkg::OFF_CTRL:    ctrl_q    <= merge(ctrl_q, s_axi_wdata, s_axi_wstrb);
                io_mux_pkg::OFF_DELAY:   delay_q   <= 24'(merge({8'h00, delay_q}, s_axi_wdata,
                                                            s_axi_wstrb));
                io_mux_pkg::OFF_EXPTIME: exptime_q <= 24'(merge({8'h00, exptime_q}, s_axi_wdata,
                                                            s_axi_wstrb));
                default: ;
            endcase
        end
    end

    // write response
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr <= io_mux_pkg::OFF_EXPTIME &&
                             s_axi_awaddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read decode
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            io_mux_pkg::OFF_IN_MAP:  rd_word = in_map_q;
            io_mux_pkg::OFF_OUT_MAP: rd_word = out_map_q;
            io_mux_pkg::OFF_CTRL:    rd_word = ctrl_q;
            io_mux_pkg::OFF_DELAY:   rd_word = {8'h00, delay_q};
            io_mux_pkg::OFF_EXPTIME: rd_word = {8'h00, exptime_q};
            io_mux_pkg::OFF_STATUS:  rd_word = status;
            default:                 rd_hit  = 1'b0;
        endcase
    end

    // read data channel
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // input side
    // ------------------------------------------------------------
    logic [3:0] pin_meta_q, pin_sync_q, lvl, lvl_prev_q;
    io_mux_pkg::in_cfg_s [3:0] icfg;
    logic [3:0] is_comp, is_ext, is_expo, is_ls, is_fs;

    assign icfg = in_map_q[15:0];

    // two-flop synchroniser on the pins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end else begin
            pin_meta_q <= {general_input_b, general_input_a, cc2, cc1};
            pin_sync_q <= pin_meta_q;
        end
    end

    // polarity first, then function decode
    for (genvar i = 0; i < io_mux_pkg::N_IN; i++) begin : g_in
        assign lvl[i]     = pin_sync_q[i] ^ icfg[i].active_low;
        assign is_comp[i] = icfg[i].func == io_mux_pkg::IF_COMP;
        assign is_ext[i]  = icfg[i].func == io_mux_pkg::IF_EXT;
        assign is_expo[i] = icfg[i].func == io_mux_pkg::IF_EXPO;
        assign is_ls[i]   = icfg[i].func == io_mux_pkg::IF_LSYNC;
        assign is_fs[i]   = icfg[i].func == io_mux_pkg::IF_FSYNC;
    end

    // previous levels
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_prev_q <= 4'h0;
        end else begin
            lvl_prev_q <= lvl;
        end
    end

    logic [3:0] rise;
    assign rise = lvl & ~lvl_prev_q;

    // input functions
    assign computer_trigger = |(lvl[1:0] & is_comp[1:0]);
    assign external_trigger = |(lvl[3:2] & is_ext[3:2]);
    assign ext_exposure     = |(lvl & is_expo) & ctrl_q[io_mux_pkg::CTRL_EXT_EXP];
    assign line_align       = |(rise & is_ls);
    assign frame_align      = |(rise & is_fs);

    // ------------------------------------------------------------
    // trigger source and microsecond tick
    // ------------------------------------------------------------
    logic       trig;
    logic [1:0] tsrc;
    logic [3:0] us_cnt_q;
    logic       us_tick;

    assign tsrc = ctrl_q[io_mux_pkg::CTRL_TSRC_LO +: 2];
    always_comb begin
        unique case (tsrc)
            io_mux_pkg::TS_EXT:  trig = external_trigger;
            io_mux_pkg::TS_COMP: trig = computer_trigger;
            io_mux_pkg::TS_PGEN: trig = pulse_gen;
            default:             trig = 1'b0;
        endcase
    end

    assign us_tick = us_cnt_q == 4'(io_mux_pkg::US_CYC - 1);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            us_cnt_q <= 4'h0;
        end else begin
            us_cnt_q <= us_tick ? 4'h0 : us_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // delayed trigger: wait, then replay the measured width
    // ------------------------------------------------------------
    typedef enum logic [1:0] {DT_IDLE, DT_WAIT, DT_PLAY} dt_state_e;
    dt_state_e dt_q;
    logic      trig_prev_q, measuring_q;
    logic [io_mux_pkg::DELAY_W-1:0] dly_cnt_q;
    logic [31:0] width_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dt_q        <= DT_IDLE;
            trig_prev_q <= 1'b0;
            measuring_q <= 1'b0;
            dly_cnt_q   <= '0;
            width_q     <= 32'h0000_0000;
        end else begin
            trig_prev_q <= trig;
            if (!trig) begin
                measuring_q <= 1'b0;
            end
            unique case (dt_q)
                DT_IDLE: begin
                    if (trig && !trig_prev_q) begin
                        dt_q        <= DT_WAIT;
                        dly_cnt_q   <= delay_q;
                        measuring_q <= 1'b1;
                        width_q     <= 32'h0000_0001;
                    end
                end
                DT_WAIT: begin
                    if (measuring_q && trig) begin
                        width_q <= width_q + 32'h1;
                    end
                    if (dly_cnt_q == '0) begin
                        dt_q <= DT_PLAY;
                    end else if (us_tick) begin
                        dly_cnt_q <= dly_cnt_q - 24'h1;
                    end
                end
                DT_PLAY: begin
                    if (!(measuring_q && trig)) begin
                        width_q <= width_q - 32'h1;
                        if (width_q == 32'h1) begin
                            dt_q <= DT_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign exposure_delay_done = dt_q == DT_PLAY;

    // ------------------------------------------------------------
    // exposure events and 2 us markers
    // ------------------------------------------------------------
    logic exp_prev_q, mid_done_q;
    logic [io_mux_pkg::DELAY_W-1:0] exp_us_q;
    logic [4:0] mark_evt, mark_q;
    logic [4:0][4:0] mark_cnt_q;

    // elapsed exposure for midpoint
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            exp_prev_q <= 1'b0;
            exp_us_q   <= '0;
            mid_done_q <= 1'b0;
        end else begin
            exp_prev_q <= exposure_active;
            if (exposure_active && !exp_prev_q) begin
                exp_us_q   <= '0;
                mid_done_q <= 1'b0;
            end else if (exposure_active && us_tick) begin
                exp_us_q <= exp_us_q + 24'h1;
            end
            if (mark_evt[2]) begin
                mid_done_q <= 1'b1;
            end
        end
    end

    assign mark_evt[0] = trigger_mode & exposure_active & ~exp_prev_q;
    assign mark_evt[1] = trigger_mode & ~exposure_active & exp_prev_q;
    assign mark_evt[2] = trigger_mode & exposure_active & exp_prev_q & ~mid_done_q
                         & (exp_us_q >= (exptime_q >> 1));
    assign mark_evt[3] = line_tick;
    assign mark_evt[4] = frame_tick;

    // one stretcher per marker
    for (genvar m = 0; m < 5; m++) begin : g_mark
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                mark_cnt_q[m] <= 5'h00;
            end else if (mark_evt[m]) begin
                mark_cnt_q[m] <= 5'(io_mux_pkg::PULSE_CYC);
            end else if (mark_cnt_q[m] != 5'h00) begin
                mark_cnt_q[m] <= mark_cnt_q[m] - 5'h01;
            end
        end
        assign mark_q[m] = mark_cnt_q[m] != 5'h00;
    end

    // frame parity: first frame after reset is odd
    logic odd_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            odd_q <= 1'b0;
        end else if (frame_tick) begin
            odd_q <= ~odd_q;
        end
    end

    // ------------------------------------------------------------
    // output side
    // ------------------------------------------------------------
    logic [15:0] src_vec;
    logic [2:0]  opin_q;
    io_mux_pkg::out_cfg_s [2:0] ocfg;

    assign ocfg = out_map_q[23:0];
    assign src_vec = {2'b00,
                      strobe_two,
                      strobe_one,
                      pulse_gen,
                      camera_ready,
                      exposure_delay_done,
                      trig,
                      ~odd_q,
                      mark_q[4], mark_q[3],
                      trigger_mode & exposure_active,
                      mark_q[2], mark_q[1], mark_q[0],
                      1'b0};

    // select then polarity
    for (genvar o = 0; o < io_mux_pkg::N_OUT; o++) begin : g_out
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                opin_q[o] <= 1'b0;
            end else begin
                opin_q[o] <= src_vec[ocfg[o].src] ^ ocfg[o].active_low;
            end
        end
    end

    assign general_output_a  = opin_q[0];
    assign general_output_b  = opin_q[1];
    assign spare_link_output = opin_q[2];

    // status word
    assign status = {23'h000000, dt_q != DT_IDLE, odd_q, opin_q, pin_sync_q};

endmodule : camera_io_signal_mux
`default_nettype wire

//--- camera_io_signal_mux_checker.sv
/*
 * port checks for the camera pin mux
 * assumes binding by port name
 */
`timescale 1ns/1ps
`default_nettype none
module camera_io_signal_mux_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins and functions
    input wire logic cc1,
    input wire logic cc2,
    input wire logic general_input_a,
    input wire logic general_input_b,
    input wire logic computer_trigger,
    input wire logic external_trigger,
    input wire logic line_align,
    input wire logic frame_align
);
    // mclk, quiet in reset
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // ----------
    // register bus
    // ----------
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write answer late");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_bresp_held: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_rresp_held: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    chk_write_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answer pending");
    // ----------
    // input functions
    // ----------
    chk_line_once: assert property (
        line_align |=> !line_align)
        else $error("line align wider than one cycle");
    chk_frame_once: assert property (
        frame_align |=> !frame_align)
        else $error("frame align wider than one cycle");
    chk_comp_from_cc: assert property (
        !s_axi_bvalid && $past(cc1, 2) == $past(cc1, 3) && $past(cc2, 2) == $past(cc2, 3)
        |-> $stable(computer_trigger))
        else $error("computer trigger moved without cc pins");
    chk_ext_from_gen: assert property (
        !s_axi_bvalid && $past(general_input_a, 2) == $past(general_input_a, 3)
        && $past(general_input_b, 2) == $past(general_input_b, 3)
        |-> $stable(external_trigger))
        else $error("external trigger moved without general pins");
endmodule : camera_io_signal_mux_checker
bind camera_io_signal_mux camera_io_signal_mux_checker camera_io_signal_mux_checker_inst (.*);
`default_nettype wire

//--- cam_pin_source.sv
/*
 * far side model: sources on the four input pins
 * assumes pins change just after mclk
 */
`timescale 1ns/1ps
`default_nettype none
module cam_pin_source (
    // clock
    input  wire logic       mclk,
    // cc1, cc2, general a, general b
    output logic      [3:0] pin_q
);
    // pins idle low until told otherwise
    initial pin_q = 4'h0;
    // set all pins
    task automatic set_pins(input logic [3:0] v);
        @(posedge mclk);
        pin_q <= v;
    endtask : set_pins
    // pulse of n whole cycles
    task automatic pulse(input int idx, input int n);
        @(posedge mclk);
        pin_q[idx] <= 1'b1;
        repeat (n) @(posedge mclk);
        pin_q[idx] <= 1'b0;
    endtask : pulse
endmodule : cam_pin_source
`default_nettype wire

//--- camera_io_signal_mux_test.sv
/*
 * self-checking bench for the camera pin mux
 * assumes the pin model and bound checker
 */
`timescale 1ns/1ps
`default_nettype none
module camera_io_signal_mux_test;
    // ----------
    // signals
    // ----------
    logic        mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire         cc1, cc2, general_input_a, general_input_b;
    logic        general_output_a, general_output_b, spare_link_output;
    logic        trigger_mode, exposure_active, line_tick, frame_tick;
    logic        camera_ready, pulse_gen, strobe_one, strobe_two;
    logic        computer_trigger, external_trigger, ext_exposure;
    logic        line_align, frame_align, exposure_delay_done, odd;
    logic [2:0]  f;
    int          n_mismatch, compares, n_line, n_frame, n_hi, base;
    logic [31:0] imap [4] = '{32'h0000_4231, 32'h0000_4231, 32'h0000_4A39, 32'h0000_4122};
    logic [3:0]  msrc [7] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
    int          mlen [7] = '{20, 20, 10, 20, 20, 10, 10};

    camera_io_signal_mux camera_io_signal_mux_inst (.*);
    cam_pin_source cam_pin_source_inst (
        .mclk  (mclk),
        .pin_q ({general_input_b, general_input_a, cc2, cc1})
    );
    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // count settled highs
    always @(negedge mclk) begin
        n_line  += (line_align === 1'b1);
        n_frame += (frame_align === 1'b1);
        n_hi    += (general_output_a === 1'b1);
    end
    // ----------
    // tasks
    // ----------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chkb(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask : chkb
    task automatic wrk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do @(negedge mclk); while (!s_axi_awready);
        @(posedge mclk);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(negedge mclk); while (!s_axi_bvalid);
        @(posedge mclk);
        s_axi_bready <= 1'b1;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge mclk);
        s_axi_bready <= 1'b0;
    endtask : wrk
    task automatic rdk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'b00);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge mclk); while (!s_axi_arready);
        @(posedge mclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge mclk); while (!s_axi_rvalid);
        @(posedge mclk);
        s_axi_rready <= 1'b1;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        @(posedge mclk);
        s_axi_rready <= 1'b0;
    endtask : rdk
    // input function model
    function automatic logic [2:0] fn_model(input logic [31:0] m, input logic c,
                                            input logic [3:0] p);
        logic [2:0] r;
        logic       v;
        r = 3'h0;
        for (int i = 0; i < 4; i++) begin
            v = p[i] ^ m[4*i+3];
            case (m[4*i +: 3])
                io_mux_pkg::IF_COMP: r[0] |= v & (i < 2);
                io_mux_pkg::IF_EXT:  r[1] |= v & (i >= 2);
                io_mux_pkg::IF_EXPO: r[2] |= v & c;
                default: ;
            endcase
        end
        return r;
    endfunction : fn_model
    task automatic stop_test;
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // watchdog
    initial begin
        #1_000_000;
        n_mismatch++;
        stop_test();
    end
    // ----------
    // main sequence
    // ----------
    initial begin
        void'($urandom(32'hBD5F987F));
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {trigger_mode, exposure_active, line_tick, frame_tick} = 4'h0;
        {camera_ready, pulse_gen, strobe_one, strobe_two} = 4'h0;
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rdk(io_mux_pkg::OFF_IN_MAP, io_mux_pkg::IN_MAP_RST);
        rdk(io_mux_pkg::OFF_OUT_MAP, io_mux_pkg::OUT_MAP_RST);
        rdk(io_mux_pkg::OFF_CTRL, io_mux_pkg::CTRL_RST);
        rdk(8'h18, 32'h0, 2'b10);
        wrk(io_mux_pkg::OFF_STATUS, 32'hFFFF_FFFF, 2'b10);
        // outputs follow their chosen sources
        for (int k = 0; k < 16; k++) begin
            if (k == 8) wrk(io_mux_pkg::OFF_OUT_MAP, 32'h000A_1B0D);
            @(posedge mclk);
            {strobe_one, strobe_two, pulse_gen, camera_ready} <= 4'($urandom);
            @(posedge mclk);
            @(negedge mclk);
            chkb("out_a", k < 8 ? strobe_one : strobe_two, general_output_a);
            chkb("out_b", k >= 8 && !pulse_gen, general_output_b);
            chkb("spare", k >= 8 && camera_ready, spare_link_output);
        end
        // frame parity
        wrk(io_mux_pkg::OFF_OUT_MAP, 32'h0017_1007);
        odd = 1'b0;
        repeat (3) begin
            @(negedge mclk);
            chkb("parity", !odd, general_output_a);
            chkb("idle", 1'b1, general_output_b);
            chkb("parity_low", odd, spare_link_output);
            @(posedge mclk);
            frame_tick <= 1'b1;
            @(posedge mclk);
            frame_tick <= 1'b0;
            odd = !odd;
            @(posedge mclk);
        end
        // input mapping
        for (int k = 0; k < 4; k++) begin
            wrk(io_mux_pkg::OFF_IN_MAP, imap[k]);
            wrk(io_mux_pkg::OFF_CTRL, {31'h0, k > 0});
            repeat (6) begin
                cam_pin_source_inst.set_pins(4'($urandom));
                repeat (2) @(posedge mclk);
                @(negedge mclk);
                f = fn_model(imap[k], k > 0, {general_input_b, general_input_a, cc2, cc1});
                chkb("comp", f[0], computer_trigger);
                chkb("ext", f[1], external_trigger);
                chkb("expo", f[2], ext_exposure);
            end
        end
        // one align per mapped pulse, none from the unmapped general a pulse
        cam_pin_source_inst.set_pins(4'h0);
        wrk(io_mux_pkg::OFF_IN_MAP, 32'h0000_5040);
        repeat (4) @(posedge mclk);
        base = n_line;
        cam_pin_source_inst.pulse(1, 1);
        cam_pin_source_inst.pulse(2, 3);
        repeat (6) @(posedge mclk);
        chk("line_aligns", 32'd1, n_line - base);
        base = n_frame;
        cam_pin_source_inst.pulse(3, 20);
        repeat (6) @(posedge mclk);
        chk("frame_aligns", 32'd1, n_frame - base);
        // marker and trigger lengths
        {trigger_mode, pulse_gen} <= 2'h2;
        wrk(io_mux_pkg::OFF_CTRL, 32'h4);
        wrk(io_mux_pkg::OFF_DELAY, 32'h1);
        for (int k = 0; k < 7; k++) begin
            wrk(io_mux_pkg::OFF_OUT_MAP, {28'h0, msrc[k]});
            repeat (25) @(posedge mclk);
            base = n_hi;
            {pulse_gen, exposure_active, line_tick, frame_tick} <= 4'hF;
            @(posedge mclk);
            {line_tick, frame_tick} <= 2'h0;
            repeat (9) @(posedge mclk);
            {pulse_gen, exposure_active} <= 2'h0;
            repeat (40) @(posedge mclk);
            chk("marker_len", mlen[k], n_hi - base);
        end
        stop_test();
    end
endmodule : camera_io_signal_mux_test
`default_nettype wire
